// *** rtl/iwr_pkg.sv ***
package iwr_pkg;

	// ************************************************
	// register map, word index on the 2-bit address
	// ************************************************
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [1:0] IDX_POWER_CONTROL = 2'h0;
	localparam logic [1:0] IDX_CLOCK_STATUS = 2'h1;
	localparam logic [1:0] IDX_RESET_CAUSE_STATUS = 2'h2;
	localparam logic [1:0] IDX_LAST_RESET_CAUSE = 2'h3;

	// power control fields
	localparam int PC_IDLE_ENABLE = 0;
	localparam int PC_CLOCK_SELECT_LO = 1;
	localparam logic PC_IDLE_ENABLE_RST = 1'b0;
	localparam logic [1:0] PC_CLOCK_SELECT_RST = 2'h2;

	// reset cause status fields and values after power-up
	localparam int RS_INTERRUPT_PRIORITY_ENABLE = 7;
	localparam int RS_CM = 5;
	localparam int RS_RI = 4;
	localparam int RS_TO = 3;
	localparam int RS_PD = 2;
	localparam int RS_POR = 1;
	localparam int RS_BOR = 0;
	localparam logic [7:0] RS_RESET_VALUE = 8'h3C;
	localparam logic [7:0] RS_WRITE_MASK = 8'hB3;

	// clock select codes
	localparam logic [1:0] CS_SECONDARY = 2'h1;
	localparam logic [1:0] CS_PRIMARY = 2'h2;
	localparam logic [1:0] CS_INTERNAL = 2'h3;

	// primary oscillator configuration codes that need no start-up timer
	localparam logic [1:0] POC_EXT_CLOCK = 2'h1;
	localparam logic [1:0] POC_EXT_CLOCK_PLL = 2'h3;

	// ************************************************
	// enumerations
	// ************************************************
	typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} iwr_src_t;
	typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP, PM_WAKE} iwr_mode_t;
	typedef enum logic [3:0] {
		RC_NONE, RC_MASTER_CLEAR_RUN, RC_MASTER_CLEAR_PM, RC_POWER_ON, RC_BROWN_OUT,
		RC_CONFIG_MISMATCH, RC_RESET_INSTR, RC_STACK_FULL, RC_STACK_UNDERFLOW, RC_WATCHDOG
	} iwr_cause_t;

	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_PS = 25000;
	localparam int WAKE_DELAY_NS = 1000;
	localparam int WAKE_DELAY_CYCLES = (WAKE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_CNT_W = 12;

endpackage

// *** rtl/iwr_idle_wake_reset.sv ***
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module iwr_idle_wake_reset #(
	parameter int IRQ_N = 8,
	parameter int WAKE_CYCLES = iwr_pkg::WAKE_DELAY_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire logic [iwr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [iwr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [iwr_pkg::DATA_W-1:0] reg_rdata,
	// core events
	input wire logic sleep_exec,
	input wire logic watchdog_clear_instruction,
	input wire logic global_interrupt_enable,
	input wire logic [IRQ_N-1:0] irq_flags,
	input wire logic [IRQ_N-1:0] irq_enables,
	// watchdog and reset events
	input wire logic watchdog_timeout,
	input wire logic watchdog_enable,
	input wire logic reset_event,
	input wire iwr_pkg::iwr_cause_t reset_kind,
	// oscillators
	input wire logic secondary_osc_enable,
	input wire logic [1:0] primary_osc_config,
	input wire logic fail_safe_enable,
	input wire logic clock_source_lost,
	input wire logic primary_osc_stable,
	input wire logic regulator_enable_pin,
	// core side outputs
	output logic cpu_clock_en,
	output logic resume_pulse,
	output logic vector_branch_pulse,
	output logic watchdog_counter_clear,
	output logic watchdog_reset,
	output logic interrupt_priority_enable,
	// clock side outputs
	output iwr_pkg::iwr_src_t periph_clock_src,
	output logic primary_osc_on,
	output logic internal_osc_on,
	output logic osc_startup_timer_run,
	output logic osc_ready_status,
	output logic secondary_running_status
);
	import iwr_pkg::*;

	// ************************************************
	// decode helpers
	// ************************************************
	// both 11 and a cleared select mean the internal oscillator
	function automatic iwr_src_t src_of(input logic [1:0] cs);
		iwr_src_t s;
		s = SRC_INTERNAL;
		if (cs == CS_PRIMARY) begin
			s = SRC_PRIMARY;
		end else if (cs == CS_SECONDARY) begin
			s = SRC_SECONDARY;
		end
		return s;
	endfunction

	// ************************************************
	// state
	// ************************************************
	iwr_mode_t mode_reg, mode_next;
	iwr_src_t src_reg, src_next;
	logic idle_enable_reg;
	logic [1:0] clock_select_reg;
	logic [7:0] rs_reg, rs_next;
	iwr_cause_t cause_reg;
	logic [WAKE_CNT_W-1:0] wake_cnt_reg, wake_cnt_next;
	logic ost_reg, ost_next;
	logic wake_irq_reg, wake_irq_next;
	logic osc_ready_reg, osc_ready_next;
	logic secondary_run_reg, secondary_run_next;
	logic reg_sync1_reg, reg_sync2_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic cpu_en_reg, resume_reg, branch_reg, wdt_clr_reg, wdt_rst_reg;
	logic pri_on_reg, int_on_reg;

	// ************************************************
	// event decode
	// ************************************************
	wire logic in_pm = (mode_reg == PM_IDLE) || (mode_reg == PM_SLEEP);
	wire logic irq_wake = |(irq_flags & irq_enables);
	wire logic wdt_wake = in_pm && watchdog_timeout;
	wire logic wdt_in_run = !in_pm && (mode_reg != PM_WAKE) && watchdog_timeout;
	wire logic pm_wake = (in_pm && irq_wake) || wdt_wake;
	wire iwr_src_t sel_src = src_of(clock_select_reg);
	wire logic sec_refused = (sel_src == SRC_SECONDARY) && !secondary_osc_enable;
	wire logic sleep_take = (mode_reg == PM_RUN) && sleep_exec && !(idle_enable_reg && sec_refused);
	wire logic ext_clock = (primary_osc_config == POC_EXT_CLOCK) || (primary_osc_config == POC_EXT_CLOCK_PLL);
	wire logic wr_rs = reg_wr && (reg_addr == IDX_RESET_CAUSE_STATUS);
	wire logic wr_pc = reg_wr && (reg_addr == IDX_POWER_CONTROL);
	wire logic regulator_on = reg_sync2_reg;
	wire logic wdt_clear_evt = sleep_exec || watchdog_clear_instruction || (clock_source_lost && fail_safe_enable);

	// ************************************************
	// mode and clock source sequencing
	// ************************************************
	always_comb begin
		mode_next = mode_reg;
		src_next = src_reg;
		wake_cnt_next = wake_cnt_reg;
		ost_next = ost_reg;
		wake_irq_next = wake_irq_reg;
		osc_ready_next = osc_ready_reg;
		secondary_run_next = secondary_run_reg;
		case (mode_reg)
			PM_RUN: begin
				// run mode switches source; secondary refused while disabled
				if (!sec_refused) begin
					src_next = sel_src;
					osc_ready_next = (sel_src == SRC_PRIMARY);
					secondary_run_next = (sel_src == SRC_SECONDARY);
				end
				if (sleep_take && idle_enable_reg) begin
					mode_next = PM_IDLE;
					src_next = sel_src;
					osc_ready_next = (sel_src == SRC_PRIMARY);
					secondary_run_next = (sel_src == SRC_SECONDARY);
				end else if (sleep_take) begin
					mode_next = PM_SLEEP;
					osc_ready_next = 1'b0;
					secondary_run_next = 1'b0;
				end
			end
			PM_IDLE, PM_SLEEP: begin
				if (pm_wake) begin
					mode_next = PM_WAKE;
					wake_irq_next = irq_wake && !watchdog_timeout;
					wake_cnt_next = WAKE_CNT_W'(WAKE_CYCLES);
					// sleep wake takes the current select; idle keeps its source
					if (mode_reg == PM_SLEEP) begin
						src_next = sel_src;
						ost_next = (sel_src == SRC_PRIMARY) && !ext_clock;
					end else begin
						ost_next = 1'b0;
					end
				end
			end
			PM_WAKE: begin
				// start-up timer first, then the fixed delay
				if (ost_reg) begin
					if (primary_osc_stable) begin
						ost_next = 1'b0;
					end
				end else if (wake_cnt_reg <= WAKE_CNT_W'(1)) begin
					mode_next = PM_RUN;
					wake_cnt_next = '0;
					osc_ready_next = (src_reg == SRC_PRIMARY);
					secondary_run_next = (src_reg == SRC_SECONDARY);
				end else begin
					wake_cnt_next = wake_cnt_reg - WAKE_CNT_W'(1);
				end
			end
			default: begin
				mode_next = PM_RUN;
			end
		endcase
		// a reset out of any power-managed state lands on internal
		if (reset_event) begin
			mode_next = PM_RUN;
			ost_next = 1'b0;
			wake_cnt_next = '0;
			if (mode_reg != PM_RUN) begin
				src_next = SRC_INTERNAL;
				osc_ready_next = 1'b0;
				secondary_run_next = 1'b0;
			end
		end
	end

	// ************************************************
	// reset cause status flags
	// ************************************************
	// software value first, then hardware events so a hardware event wins
	always_comb begin
		rs_next = rs_reg;
		if (wr_rs) begin
			rs_next = (rs_reg & ~RS_WRITE_MASK) | (reg_wdata & RS_WRITE_MASK);
		end
		if (watchdog_clear_instruction) begin
			rs_next[RS_TO] = 1'b1;
			rs_next[RS_PD] = 1'b1;
		end
		if (sleep_exec) begin
			rs_next[RS_TO] = 1'b1;
			rs_next[RS_PD] = 1'b0;
		end
		if (watchdog_timeout) begin
			rs_next[RS_TO] = 1'b0;
		end
		if (reset_event) begin
			case (reset_kind)
				RC_CONFIG_MISMATCH: rs_next[RS_CM] = 1'b0;
				RC_RESET_INSTR: rs_next[RS_RI] = 1'b0;
				RC_POWER_ON: begin
					rs_next = RS_RESET_VALUE | (rs_next & 8'h80);
				end
				RC_BROWN_OUT: begin
					rs_next[RS_BOR] = 1'b0;
					rs_next[RS_CM] = 1'b1;
					rs_next[RS_RI] = 1'b1;
					rs_next[RS_TO] = 1'b1;
					rs_next[RS_PD] = 1'b1;
				end
				default: begin
					rs_next = rs_next;
				end
			endcase
		end
		rs_next[6] = 1'b0;
		if (!regulator_on) begin
			rs_next[RS_BOR] = 1'b0;
		end
	end

	// cause code, master clear split by power-managed state
	wire iwr_cause_t cause_next = (reset_event && reset_kind == RC_MASTER_CLEAR_RUN && mode_reg != PM_RUN) ? RC_MASTER_CLEAR_PM
		: reset_event ? reset_kind : wdt_in_run ? RC_WATCHDOG : cause_reg;

	// read mux; unmapped bits read zero
	wire logic [DATA_W-1:0] rd_mux = (reg_addr == IDX_POWER_CONTROL) ? {5'h00, clock_select_reg, idle_enable_reg}
		: (reg_addr == IDX_CLOCK_STATUS) ? {2'h0, mode_reg, src_reg, secondary_run_reg, osc_ready_reg}
		: (reg_addr == IDX_RESET_CAUSE_STATUS) ? rs_reg
		: {4'h0, cause_reg};

	// ************************************************
	// registers
	// ************************************************
	// regulator strap comes from a pin, so two stages first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_sync1_reg <= 1'b0;
			reg_sync2_reg <= 1'b0;
		end else begin
			reg_sync1_reg <= regulator_enable_pin;
			reg_sync2_reg <= reg_sync1_reg;
		end
	end

	// sequencing state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_reg <= PM_RUN;
			src_reg <= SRC_PRIMARY;
			wake_cnt_reg <= '0;
			ost_reg <= 1'b0;
			wake_irq_reg <= 1'b0;
			osc_ready_reg <= 1'b1;
			secondary_run_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			src_reg <= src_next;
			wake_cnt_reg <= wake_cnt_next;
			ost_reg <= ost_next;
			wake_irq_reg <= wake_irq_next;
			osc_ready_reg <= osc_ready_next;
			secondary_run_reg <= secondary_run_next;
		end
	end

	// software fields; wake never touches them
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			idle_enable_reg <= PC_IDLE_ENABLE_RST;
			clock_select_reg <= PC_CLOCK_SELECT_RST;
		end else if (reset_event && (mode_reg != PM_RUN)) begin
			// select follows, else run mode would switch straight back
			clock_select_reg <= CS_INTERNAL;
		end else if (wr_pc) begin
			idle_enable_reg <= reg_wdata[PC_IDLE_ENABLE];
			clock_select_reg <= reg_wdata[PC_CLOCK_SELECT_LO +: 2];
		end
	end

	// status flags and cause
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rs_reg <= RS_RESET_VALUE;
			cause_reg <= RC_POWER_ON;
		end else begin
			rs_reg <= rs_next;
			cause_reg <= cause_next;
		end
	end

	// registered outputs; read data stands one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_reg <= '0;
			cpu_en_reg <= 1'b1;
			resume_reg <= 1'b0;
			branch_reg <= 1'b0;
			wdt_clr_reg <= 1'b0;
			wdt_rst_reg <= 1'b0;
			pri_on_reg <= 1'b1;
			int_on_reg <= 1'b0;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : '0;
			cpu_en_reg <= (mode_next == PM_RUN);
			resume_reg <= (mode_reg == PM_WAKE) && (mode_next == PM_RUN) && !reset_event;
			branch_reg <= (mode_reg == PM_WAKE) && (mode_next == PM_RUN) && !reset_event
				&& wake_irq_reg && global_interrupt_enable;
			wdt_clr_reg <= wdt_clear_evt;
			wdt_rst_reg <= wdt_in_run;
			// primary stopped in sleep and whenever another source runs
			pri_on_reg <= (src_next == SRC_PRIMARY) && (mode_next != PM_SLEEP);
			int_on_reg <= ((src_next == SRC_INTERNAL) && (mode_next != PM_SLEEP))
				|| watchdog_enable || fail_safe_enable;
		end
	end

	// ************************************************
	// output wiring
	// ************************************************
	assign reg_rdata = rdata_reg;
	assign cpu_clock_en = cpu_en_reg;
	assign resume_pulse = resume_reg;
	assign vector_branch_pulse = branch_reg;
	assign watchdog_counter_clear = wdt_clr_reg;
	assign watchdog_reset = wdt_rst_reg;
	assign interrupt_priority_enable = rs_reg[RS_INTERRUPT_PRIORITY_ENABLE];
	assign periph_clock_src = src_reg;
	assign primary_osc_on = pri_on_reg;
	assign internal_osc_on = int_on_reg;
	assign osc_startup_timer_run = ost_reg;
	assign osc_ready_status = osc_ready_reg;
	assign secondary_running_status = secondary_run_reg;

endmodule

// *** tb/iwr_osc_model.sv ***
`timescale 1ns/1ps
// ************************
// primary oscillator model
// ************************
module iwr_osc_model #(
	parameter int START_CYCLES = 20
) (
	// clock and reset
	input logic ref_clk,
	input logic rst,
	// oscillator side
	input logic primary_osc_on,
	output logic primary_osc_stable
);
	int cnt;
	// warm-up restarts on every stop, never ready early
	always_ff @(posedge ref_clk) begin
		if (rst || !primary_osc_on) begin
			cnt <= 0;
		end else if (cnt < START_CYCLES) begin
			cnt <= cnt + 1;
		end
	end
	assign primary_osc_stable = primary_osc_on && cnt == START_CYCLES;
endmodule

// *** tb/iwr_chk.sv ***
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module iwr_chk #(
	parameter int IRQ_N = 8,
	parameter int WAKE_CYCLES = iwr_pkg::WAKE_DELAY_CYCLES
) (
	// clock and reset
	input logic ref_clk,
	input logic rst,
	// core events
	input logic sleep_exec,
	input logic global_interrupt_enable,
	input logic [IRQ_N-1:0] irq_flags,
	input logic [IRQ_N-1:0] irq_enables,
	input logic watchdog_timeout,
	input logic reset_event,
	// outputs
	input logic cpu_clock_en,
	input logic resume_pulse,
	input logic vector_branch_pulse,
	input logic watchdog_counter_clear,
	input logic watchdog_reset,
	input iwr_pkg::iwr_src_t periph_clock_src,
	input logic primary_osc_on,
	input logic osc_ready_status,
	input logic secondary_running_status
);
	import iwr_pkg::*;
	localparam int WK = WAKE_CYCLES + 1;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ****************
	// properties
	// ****************
	property p_clr; sleep_exec |=> watchdog_counter_clear; endproperty
	a_clr: assert property (p_clr) else $error("no counter clear after sleep");
	property p_wrst; watchdog_reset |-> $past(watchdog_timeout) && $past(cpu_clock_en); endproperty
	a_wrst: assert property (p_wrst) else $error("stray watchdog reset");
	property p_wwake; watchdog_timeout && !cpu_clock_en |=> !watchdog_reset; endproperty
	a_wwake: assert property (p_wwake) else $error("watchdog reset while halted");
	property p_vec; vector_branch_pulse |-> resume_pulse && $past(global_interrupt_enable); endproperty
	a_vec: assert property (p_vec) else $error("bad vector branch");
	property p_res; resume_pulse |-> cpu_clock_en && !$past(cpu_clock_en); endproperty
	a_res: assert property (p_res) else $error("resume without halt");
	property p_pidle; $fell(cpu_clock_en) && primary_osc_on |-> osc_ready_status; endproperty
	a_pidle: assert property (p_pidle) else $error("ready lost in primary idle");
	property p_sidle; $fell(cpu_clock_en) && secondary_running_status |-> !primary_osc_on && !osc_ready_status;
	endproperty
	a_sidle: assert property (p_sidle) else $error("primary left on in secondary idle");
	// fixed delay only where the primary never stopped
	property p_wake; $rose(|(irq_flags & irq_enables)) && !cpu_clock_en && osc_ready_status |-> ##WK resume_pulse;
	endproperty
	a_wake: assert property (p_wake) else $error("wake delay wrong");
	property p_rst; reset_event && !cpu_clock_en |-> ##[1:2] periph_clock_src == SRC_INTERNAL; endproperty
	a_rst: assert property (p_rst) else $error("reset exit not internal");
	// main scenarios
	c_res: cover property (resume_pulse);
	c_vec: cover property (vector_branch_pulse);
	c_wrst: cover property (watchdog_reset);
endmodule
bind iwr_idle_wake_reset iwr_chk #(.IRQ_N(IRQ_N), .WAKE_CYCLES(WAKE_CYCLES)) u_chk (.ref_clk, .rst, .sleep_exec,
	.global_interrupt_enable, .irq_flags, .irq_enables, .watchdog_timeout, .reset_event, .cpu_clock_en,
	.resume_pulse, .vector_branch_pulse, .watchdog_counter_clear, .watchdog_reset, .periph_clock_src,
	.primary_osc_on, .osc_ready_status, .secondary_running_status);

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
`define PULSE(s) begin @(posedge ref_clk) s <= 1'h1; @(posedge ref_clk) s <= 1'h0; #1; end
// ****************
// bench top
// ****************
module tb;
	import iwr_pkg::*;
	localparam int W = 3;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sleep_exec = 0, watchdog_clear_instruction = 0;
	logic global_interrupt_enable = 0, watchdog_timeout = 0, watchdog_enable = 0, reset_event = 0;
	logic secondary_osc_enable = 0, fail_safe_enable = 0, clock_source_lost = 0, regulator_enable_pin = 1;
	logic [1:0] reg_addr = 0, primary_osc_config = 0;
	logic [7:0] reg_wdata = 0, irq_flags = 0, irq_enables = 0, reg_rdata;
	iwr_cause_t reset_kind = RC_NONE;
	iwr_src_t periph_clock_src;
	logic primary_osc_stable, cpu_clock_en, resume_pulse, vector_branch_pulse, watchdog_counter_clear;
	logic watchdog_reset, interrupt_priority_enable, primary_osc_on, internal_osc_on, osc_startup_timer_run;
	logic osc_ready_status, secondary_running_status;
	iwr_idle_wake_reset #(.WAKE_CYCLES(W)) u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .sleep_exec, .watchdog_clear_instruction, .global_interrupt_enable, .irq_flags, .irq_enables,
		.watchdog_timeout, .watchdog_enable, .reset_event, .reset_kind, .secondary_osc_enable, .primary_osc_config,
		.fail_safe_enable, .clock_source_lost, .primary_osc_stable, .regulator_enable_pin, .cpu_clock_en,
		.resume_pulse, .vector_branch_pulse, .watchdog_counter_clear, .watchdog_reset, .interrupt_priority_enable,
		.periph_clock_src, .primary_osc_on, .internal_osc_on, .osc_startup_timer_run, .osc_ready_status,
		.secondary_running_status);
	iwr_osc_model u_osc (.ref_clk, .rst, .primary_osc_on, .primary_osc_stable);
	always #12.5 ref_clk = ~ref_clk;
	// ****************
	// bus and event helpers
	// ****************
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask
	task automatic rst_ev(input iwr_cause_t k);
		@(posedge ref_clk);
		reset_kind <= k;
		reset_event <= 1'h1;
		@(posedge ref_clk);
		reset_event <= 1'h0;
	endtask
	// bounded so a missing wake cannot hang the run
	task automatic wait_res(output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (!resume_pulse && n < 300);
	endtask
	task automatic chk_src(input iwr_src_t s);
		`CHK(periph_clock_src, s)
		`CHK(osc_ready_status, s == SRC_PRIMARY)
		`CHK(secondary_running_status, s == SRC_SECONDARY)
		`CHK(primary_osc_on, s == SRC_PRIMARY)
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_regs;
		logic [7:0] v;
		wr(IDX_CLOCK_STATUS, 8'hFF);
		rd(IDX_CLOCK_STATUS, v);
		`CHK(v, 8'h01)
		rd(IDX_POWER_CONTROL, v);
		`CHK(v, 8'h04)
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, RS_RESET_VALUE)
		wr(IDX_RESET_CAUSE_STATUS, 8'hFF);
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'hBF)
		`CHK(interrupt_priority_enable, 1'h1)
		rst_ev(RC_CONFIG_MISMATCH);
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'h9F)
		rst_ev(RC_RESET_INSTR);
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'h8F)
		`PULSE(watchdog_timeout)
		`CHK(watchdog_reset, 1'h1)
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'h87)
		`PULSE(watchdog_clear_instruction)
		`CHK(watchdog_counter_clear, 1'h1)
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'h8F)
		rst_ev(RC_POWER_ON);
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'hBC)
		wr(IDX_RESET_CAUSE_STATUS, 8'hFF);
		rst_ev(RC_BROWN_OUT);
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'hBE)
		@(posedge ref_clk) regulator_enable_pin <= 1'h0;
		repeat (4) @(posedge ref_clk);
		wr(IDX_RESET_CAUSE_STATUS, 8'h7F);
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v, 8'h3E)
		`CHK(interrupt_priority_enable, 1'h0)
		regulator_enable_pin <= 1'h1;
		fail_safe_enable <= 1'h1;
		`PULSE(clock_source_lost)
		`CHK(watchdog_counter_clear, 1'h1)
		for (int i = 1; i < 10; i++) begin
			if (i != int'(RC_MASTER_CLEAR_PM)) begin
				rst_ev(iwr_cause_t'(i));
				rd(IDX_LAST_RESET_CAUSE, v);
				`CHK(v[3:0], i[3:0])
			end
		end
		$display("t_regs done");
	endtask
	// idle entry, a masked flag, then an enabled wake
	task automatic t_idle(input logic [7:0] pc, input iwr_src_t s, input logic gie);
		int n;
		logic [7:0] v;
		global_interrupt_enable <= gie;
		wr(IDX_POWER_CONTROL, 8'h05);
		wr(IDX_POWER_CONTROL, pc);
		repeat (30) @(posedge ref_clk);
		`PULSE(sleep_exec)
		`CHK(watchdog_counter_clear, 1'h1)
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(cpu_clock_en, 1'h0)
		chk_src(s);
		@(posedge ref_clk) irq_flags <= 8'h01;
		repeat (12) @(posedge ref_clk);
		#1;
		`CHK(cpu_clock_en, 1'h0)
		@(posedge ref_clk) irq_enables <= 8'h01;
		wait_res(n);
		`CHK(n, W + 1)
		`CHK(vector_branch_pulse, gie)
		chk_src(s);
		rd(IDX_POWER_CONTROL, v);
		`CHK(v, pc)
		irq_flags <= 8'h00;
		irq_enables <= 8'h00;
		$display("t_idle done");
	endtask
	task automatic t_refuse;
		wr(IDX_POWER_CONTROL, 8'h03);
		`PULSE(sleep_exec)
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(cpu_clock_en, 1'h1)
		secondary_osc_enable <= 1'h1;
		$display("t_refuse done");
	endtask
	task automatic t_sleep;
		int n;
		logic [7:0] v;
		`CHK(internal_osc_on, 1'h1)
		`PULSE(sleep_exec)
		repeat (2) @(posedge ref_clk);
		`PULSE(watchdog_timeout)
		wait_res(n);
		`CHK(n, W)
		`CHK(periph_clock_src, SRC_INTERNAL)
		wr(IDX_POWER_CONTROL, 8'h04);
		repeat (40) @(posedge ref_clk);
		`PULSE(sleep_exec)
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(osc_ready_status, 1'h0)
		`CHK(primary_osc_on, 1'h0)
		rd(IDX_RESET_CAUSE_STATUS, v);
		`CHK(v[3:2], 2'h2)
		irq_flags <= 8'h01;
		irq_enables <= 8'h01;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(osc_startup_timer_run, 1'h1)
		wait_res(n);
		`CHK(resume_pulse, 1'h1)
		`CHK(osc_ready_status, 1'h1)
		irq_flags <= 8'h00;
		// external clock skips the start-up timer, only the fixed delay
		primary_osc_config <= POC_EXT_CLOCK;
		`PULSE(sleep_exec)
		repeat (2) @(posedge ref_clk);
		`PULSE(watchdog_timeout)
		wait_res(n);
		`CHK(n, W)
		primary_osc_config <= 2'h0;
		`PULSE(sleep_exec)
		repeat (2) @(posedge ref_clk);
		rst_ev(RC_MASTER_CLEAR_RUN);
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(periph_clock_src, SRC_INTERNAL)
		rd(IDX_LAST_RESET_CAUSE, v);
		`CHK(v[3:0], RC_MASTER_CLEAR_PM)
		rd(IDX_POWER_CONTROL, v);
		`CHK(v[2:1], CS_INTERNAL)
		$display("t_sleep done");
	endtask
	// ****************
	// run control
	// ****************
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, far above the few hundred cycles used
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		watchdog_enable = 1'h1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		t_regs();
		t_idle(8'h05, SRC_PRIMARY, 1'h1);
		t_refuse();
		t_idle(8'h03, SRC_SECONDARY, 1'h0);
		t_idle(8'h01, SRC_INTERNAL, 1'h1);
		t_sleep();
		stop_test();
	end
endmodule
